/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [1:0] A_CTL = tec_pkg::ADDR_CTRL;
   localparam logic [1:0] A_LO  = tec_pkg::ADDR_CNT_LO;
   localparam logic [1:0] A_HI  = tec_pkg::ADDR_CNT_HI;
   localparam logic [1:0] A_INT = tec_pkg::ADDR_INTC;
   logic       clk_sys;
   logic       rstn;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       power_down;
   logic [7:0] rdata;
   logic       timer_pin;
   logic       irq;
   logic       wake_up;
   logic       ce;
   logic       sub_clock;
   logic [7:0] rdata_w;
   logic       irq_w;
   logic [7:0] vw;
   int         wake_count;
   logic [7:0] v;
   logic [7:0] w;
   int         bad_count;
   int         tests_run;

   tec_channel #(.WIDE(1'b0)) tec_channel_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_pin(timer_pin),
      .sub_clock(sub_clock), .power_down(power_down), .irq(irq), .wake_up(wake_up));
   // wide channel shares bus and pin; only its own scenario judges its answers
   tec_channel #(.WIDE(1'b1)) tec_channel_w_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_w), .timer_pin(timer_pin),
      .sub_clock(sub_clock), .power_down(power_down), .irq(irq_w), .wake_up());
   tec_pin_model tec_pin_model_i (.clk_sys(clk_sys), .timer_pin(timer_pin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (wake_up) wake_count <= wake_count + 1;

   // ==========
   // bus and compare tasks
   task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : cmp8
   task automatic cmp1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : cmp1
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      d  = rdata;
      vw = rdata_w;
   endtask : rd_reg
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string n);
      rd_reg(a, v);
      cmp8(n, e, v);
   endtask : rd_chk

   // ==========
   // scenarios
   task automatic t_reset;
      rd_chk(A_CTL, tec_pkg::CTRL_RESET, "ctrl_rst");
      rd_chk(A_INT, tec_pkg::INTC_RESET, "intc_rst");
      rd_chk(A_LO, tec_pkg::CNT_RESET[7:0], "cnt_rst");
      wr_reg(A_HI, 8'h5A);
      rd_chk(A_HI, 8'h00, "narrow_hi");
   endtask : t_reset
   task automatic t_timer;
      int gap;
      for (int p = 0; p < 4; p++) begin
         gap = (p < 2) ? 0 : (1 << p) - 2;
         wr_reg(A_CTL, 8'h80);
         wr_reg(A_LO, 8'h00);
         wr_reg(A_CTL, 8'h90 | 8'(p));
         rd_reg(A_LO, v);
         repeat (gap) @(posedge clk_sys);
         rd_reg(A_LO, w);
         cmp8("tick", (p == 0) ? 8'h02 : 8'h01, w - v);
      end
      // plain stop, then idle mode with run still set
      for (int i = 0; i < 2; i++) begin
         wr_reg(A_CTL, i ? 8'h10 : 8'h80);
         rd_reg(A_LO, w);
         repeat (4) @(posedge clk_sys);
         rd_chk(A_LO, w, "held");
      end
      // clock enable low for ten edges: only the two live edges count
      wr_reg(A_CTL, 8'h80);
      wr_reg(A_LO, 8'h00);
      wr_reg(A_CTL, 8'h90);
      rd_reg(A_LO, v);
      ce <= 1'b0;
      repeat (10) @(posedge clk_sys);
      ce <= 1'b1;
      rd_reg(A_LO, w);
      cmp8("frozen", 8'h02, w - v);
   endtask : t_timer
   task automatic t_ovf;
      wr_reg(A_INT, 8'h01);
      wr_reg(A_CTL, 8'h80);
      wr_reg(A_LO, 8'hFA);
      rd_chk(A_LO, 8'hFA, "load_stopped");
      wr_reg(A_CTL, 8'h90);
      wr_reg(A_LO, 8'h20);
      rd_reg(A_LO, v);
      cmp8("no_early_load", 8'hF0, v & 8'hF0);
      repeat (8) @(posedge clk_sys);
      rd_reg(A_LO, v);
      cmp8("reload", 8'h20, v & 8'hF0);
      cmp1("irq_on", 1'b1, irq);
      rd_chk(A_INT, 8'h03, "flag");
      wr_reg(A_INT, 8'h02);
      cmp1("irq_masked", 1'b0, irq);
      wr_reg(A_INT, 8'h00);
      cmp1("no_wake", 1'b0, wake_count != 0);
   endtask : t_ovf
   task automatic t_event;
      int n;
      // prescale field at its slowest must not matter here
      for (int e = 0; e < 2; e++) begin
         wr_reg(A_CTL, 8'h47 | 8'(e << 3));
         wr_reg(A_LO, 8'hFE);
         wr_reg(A_CTL, 8'h57 | 8'(e << 3));
         power_down <= 1'b1;
         n = wake_count;
         tec_pin_model_i.toggles(5);
         repeat (4) @(posedge clk_sys);
         wr_reg(A_CTL, 8'h47 | 8'(e << 3));
         power_down <= 1'b0;
         tec_pin_model_i.toggles(1);
         rd_chk(A_LO, e ? 8'hFF : 8'hFE, "events");
         cmp1("wake", 1'b1, wake_count == n + 1);
         rd_chk(A_INT, 8'h02, "ev_flag");
         wr_reg(A_INT, 8'h00);
      end
   endtask : t_event
   task automatic t_pulse;
      for (int e = 0; e < 2; e++) begin
         tec_pin_model_i.set_level(e[0]);
         wr_reg(A_CTL, 8'hC0 | 8'(e << 3));
         wr_reg(A_LO, 8'h00);
         wr_reg(A_CTL, 8'hD0 | 8'(e << 3));
         repeat (8) @(posedge clk_sys);
         rd_chk(A_LO, 8'h00, "armed");
         tec_pin_model_i.set_level(!e[0]);
         repeat (6) @(posedge clk_sys);
         // second pulse must leave the held count alone
         for (int k = 0; k < 2; k++) begin
            tec_pin_model_i.pulse(20);
            repeat (8) @(posedge clk_sys);
            rd_chk(A_CTL, 8'hC0 | 8'(e << 3), "run_cleared");
            rd_reg(A_LO, v);
            cmp1("width", 1'b1, v >= 8'h13 && v <= 8'h15);
         end
      end
   endtask : t_pulse

   task automatic t_wide;
      // low byte waits in its buffer until the high byte is written
      wr_reg(A_CTL, 8'h80);
      wr_reg(A_LO, 8'h34);
      wr_reg(A_HI, 8'h12);
      wr_reg(A_LO, 8'h56);
      rd_reg(A_HI, v);
      cmp8("wide_hi", 8'h12, vw);
      rd_reg(A_LO, v);
      cmp8("wide_lo", 8'h34, vw);
      // system clock over four: two ticks before the high read latches
      wr_reg(A_CTL, 8'h90);
      repeat (9) @(posedge clk_sys);
      rd_reg(A_HI, v);
      rd_reg(A_LO, v);
      cmp8("wide_div4", 8'h36, vw);
      // three sub clock edges from FFFE: FFFF, reload FFFE, FFFF
      wr_reg(A_INT, 8'h01);
      wr_reg(A_CTL, 8'hA0);
      wr_reg(A_LO, 8'hFE);
      wr_reg(A_HI, 8'hFF);
      wr_reg(A_CTL, 8'hB0);
      rd_reg(A_CTL, v);
      cmp8("narrow_src", 8'h90, v);
      cmp8("wide_src", 8'hB0, vw);
      repeat (3) begin
         sub_clock <= 1'b1;
         repeat (3) @(posedge clk_sys);
         sub_clock <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      wr_reg(A_CTL, 8'hA0);
      rd_reg(A_HI, v);
      cmp8("wide_full_hi", 8'hFF, vw);
      rd_reg(A_LO, v);
      cmp8("wide_full_lo", 8'hFF, vw);
      rd_reg(A_INT, v);
      cmp8("wide_flag", 8'h03, vw);
      cmp1("wide_irq", 1'b1, irq_w);
   endtask : t_wide

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      rstn       = 1'b0;
      addr       = 2'h0;
      wdata      = 8'h00;
      wr         = 1'b0;
      rd         = 1'b0;
      power_down = 1'b0;
      ce         = 1'b1;
      sub_clock  = 1'b0;
      bad_count  = 0;
      tests_run  = 0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_timer;
      t_ovf;
      t_event;
      t_pulse;
      t_wide;
      give_verdict;
   end
   // whole run is well under a thousand cycles
   initial begin
      #50000;
      bad_count++;
      give_verdict;
   end
endmodule : tb_top
`default_nettype wire

/* File: tb/tec_channel_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module tec_channel_asserts #(
   parameter bit WIDE = 1'b0
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       ce,
   // register port
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] rdata,
   // pins and events
   input  wire logic       timer_pin,
   input  wire logic       sub_clock,
   input  wire logic       power_down,
   input  wire logic       irq,
   input  wire logic       wake_up
);
   // ==========
   // shadows of software writes
   logic [7:0] ctrl_sh_reg;
   logic       en_sh_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_sh_reg <= 8'h00;
         en_sh_reg   <= 1'b0;
      end else if (wr && ce) begin
         if (addr == tec_pkg::ADDR_CTRL) ctrl_sh_reg <= wdata;
         if (addr == tec_pkg::ADDR_INTC) en_sh_reg <= wdata[0];
      end
   end

   // ==========
   // properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // pulse mode excluded: hardware may drop the run bit there
   sequence s_ctrl_rd;
      rd && addr == tec_pkg::ADDR_CTRL && ctrl_sh_reg[7:6] != 2'b11;
   endsequence
   sequence s_intc_rd;
      rd && addr == tec_pkg::ADDR_INTC;
   endsequence

   chk_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data without a read");
   chk_ctrl_readback: assert property (s_ctrl_rd |=> {rdata[7:6], rdata[4:0]} ==
      $past({ctrl_sh_reg[7:6], ctrl_sh_reg[4:0]})) else $error("control readback wrong");
   chk_intc_layout: assert property (s_intc_rd |=>
      rdata[7:2] == 6'h00 && rdata[0] == $past(en_sh_reg)) else $error("intc readback wrong");
   chk_flag_drives_irq: assert property (s_intc_rd |=>
      (rdata[1] & rdata[0]) == $past(irq)) else $error("irq differs from flag and enable");
   chk_irq_masked: assert property (!en_sh_reg |-> !irq)
      else $error("irq while disabled");
   chk_irq_follows_en: assert property (wr && addr == tec_pkg::ADDR_INTC && wdata[1]
      |=> irq == $past(wdata[0])) else $error("irq not set by flag write");
   chk_wake_in_pd: assert property (wake_up |-> $past(power_down))
      else $error("wake outside power down");
   chk_narrow_no_high: assert property (!WIDE && rd && addr == tec_pkg::ADDR_CNT_HI
      |=> rdata == 8'h00) else $error("narrow high byte not zero");
endmodule : tec_channel_asserts

bind tec_channel tec_channel_asserts #(.WIDE(WIDE)) tec_channel_asserts_i (
   .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .timer_pin(timer_pin), .sub_clock(sub_clock),
   .power_down(power_down), .irq(irq), .wake_up(wake_up));
`default_nettype wire

/* File: tb/tec_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tec_pin_model (
   // clock
   input  wire logic clk_sys,
   // pin, driven into a port set as input
   output var logic  timer_pin
);
   // idles high as a pulled-up input would
   initial timer_pin = 1'b1;
   task automatic set_level(input logic l);
      @(posedge clk_sys);
      timer_pin <= l;
   endtask : set_level
   // spaced so the synchroniser never merges two edges
   task automatic toggles(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         timer_pin <= ~timer_pin;
         repeat (3) @(posedge clk_sys);
      end
   endtask : toggles
   task automatic pulse(input int w);
      @(posedge clk_sys);
      timer_pin <= ~timer_pin;
      repeat (w) @(posedge clk_sys);
      timer_pin <= ~timer_pin;
   endtask : pulse
endmodule : tec_pin_model
`default_nettype wire

/* File: verilog/tec_channel.sv */
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tec_channel #(
   parameter bit WIDE = 1'b0
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       ce,
   // register port
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // external pins and system state
   input  wire logic       timer_pin,
   input  wire logic       sub_clock,
   input  wire logic       power_down,
   // events
   output logic            irq,
   output logic            wake_up
);

   // ==========================================================
   // helpers
   function automatic logic sel_edge(input logic pol, input logic r, input logic f);
      sel_edge = pol ? f : r;
   endfunction : sel_edge

   function automatic logic [6:0] psc_mask(input logic [2:0] psc);
      psc_mask = ~(7'h7F << psc);
   endfunction : psc_mask

   // ==========================================================
   // state
   tec_pkg::tec_ctrl_t ctrl_reg;
   tec_pkg::tec_ctrl_t ctrl_next;
   tec_pkg::tec_pw_t   pw_reg;
   tec_pkg::tec_pw_t   pw_next;
   logic [15:0]        count_reg;
   logic [15:0]        count_next;
   logic [15:0]        preload_reg;
   logic [15:0]        preload_next;
   logic [7:0]         lo_wbuf_reg;
   logic [7:0]         lo_rbuf_reg;
   logic [6:0]         psc_reg;
   logic [6:0]         psc_next;
   logic [7:0]         intc_reg;
   logic [7:0]         intc_next;
   logic [7:0]         rdata_reg;
   logic [7:0]         rdata_next;
   logic               wake_reg;

   // ==========================================================
   // pin synchronisers
   logic pin_rise;
   logic pin_fall;
   logic sub_rise;

   tec_edge_sync u_pin_sync (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .ce       (ce),
      .async_in (timer_pin),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   tec_edge_sync u_sub_sync (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .ce       (ce),
      .async_in (sub_clock),
      .rise     (sub_rise),
      .fall     ()
   );

   // ==========================================================
   // address decode
   wire wr_ctrl = wr && (addr == tec_pkg::ADDR_CTRL);
   wire wr_lo   = wr && (addr == tec_pkg::ADDR_CNT_LO);
   wire wr_hi   = wr && (addr == tec_pkg::ADDR_CNT_HI) && WIDE;
   wire wr_intc = wr && (addr == tec_pkg::ADDR_INTC);
   wire rd_hi   = rd && (addr == tec_pkg::ADDR_CNT_HI) && WIDE;

   // ==========================================================
   // mode decode
   tec_pkg::tec_mode_t mode;
   assign mode = tec_pkg::tec_mode_t'(ctrl_reg.mode);

   wire run        = ctrl_reg.run;
   wire is_timer   = (mode == tec_pkg::MODE_TIMER);
   wire is_event   = (mode == tec_pkg::MODE_EVENT);
   wire is_pulse   = (mode == tec_pkg::MODE_PULSE);
   wire measuring  = (pw_reg == tec_pkg::PW_MEASURE);

   // count edge in event mode, which is also the closing edge of a pulse
   wire count_edge = sel_edge(ctrl_reg.active_edge, pin_rise, pin_fall);
   // opening edge of a pulse: falling for select zero, rising for one
   wire start_edge = sel_edge(~ctrl_reg.active_edge, pin_rise, pin_fall);

   // ==========================================================
   // internal clock: prescaler for the narrow channel, sub clock or /4 for the wide
   wire       psc_active = run && (is_timer || (is_pulse && measuring));
   wire [6:0] mask_narrow = psc_mask(ctrl_reg.psc);
   wire       tick_narrow = ((psc_reg & mask_narrow) == mask_narrow);
   wire       tick_div4   = ((psc_reg & tec_pkg::DIV4_MASK) == tec_pkg::DIV4_MASK);
   wire       tick_wide   = ctrl_reg.clk_src ? sub_rise : tick_div4;
   wire       int_tick    = WIDE ? tick_wide : tick_narrow;

   // prescaler restarts whenever the internal clock is not in use, so a new
   // run gets a full first period, except when the wide channel runs from the sub clock
   assign psc_next = psc_active ? psc_reg + 7'h01 : 7'h00;

   // ==========================================================
   // pulse width state
   wire pw_start = run && is_pulse && !measuring && start_edge;
   wire pw_end   = run && is_pulse && measuring && count_edge;

   always_comb begin
      pw_next = pw_reg;
      if (wr_ctrl) begin
         pw_next = tec_pkg::PW_WAIT;
      end else begin
         unique case (pw_reg)
            tec_pkg::PW_WAIT: begin
               if (pw_start) begin
                  pw_next = tec_pkg::PW_MEASURE;
               end
            end
            tec_pkg::PW_MEASURE: begin
               if (pw_end || !is_pulse || !run) begin
                  pw_next = tec_pkg::PW_WAIT;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // count enable per mode
   logic count_tick;
   always_comb begin
      count_tick = 1'b0;
      if (run) begin
         unique case (mode)
            tec_pkg::MODE_IDLE:  count_tick = 1'b0;
            tec_pkg::MODE_EVENT: count_tick = count_edge;
            tec_pkg::MODE_TIMER: count_tick = int_tick;
            tec_pkg::MODE_PULSE: count_tick = measuring && !pw_end && int_tick;
         endcase
      end
   end

   wire [15:0] full     = WIDE ? tec_pkg::FULL_WIDE : tec_pkg::FULL_NARROW;
   wire        overflow = count_tick && (count_reg == full);

   // ==========================================================
   // preload and counter
   wire        pre_wr  = WIDE ? wr_hi : wr_lo;
   wire [15:0] pre_val = WIDE ? {wdata, lo_wbuf_reg} : {8'h00, wdata};

   assign preload_next = pre_wr ? pre_val : preload_reg;

   always_comb begin
      count_next = count_reg;
      if (pre_wr && !run) begin
         count_next = pre_val;
      end else if (overflow) begin
         count_next = preload_next;
      end else if (count_tick) begin
         count_next = count_reg + 16'h0001;
      end
   end

   // ==========================================================
   // control register
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = tec_pkg::tec_ctrl_t'(wdata);
         if (!WIDE) begin
            ctrl_next.clk_src = 1'b0;
         end
      end else if (pw_end) begin
         ctrl_next.run = 1'b0;
      end
   end

   // ==========================================================
   // interrupt control: enable and sticky request, overflow wins over a clear
   always_comb begin
      intc_next = intc_reg;
      if (wr_intc) begin
         intc_next = wdata & 8'h03;
      end
      if (overflow) begin
         intc_next[tec_pkg::INTC_FLAG_BIT] = 1'b1;
      end
   end

   assign irq = intc_reg[tec_pkg::INTC_FLAG_BIT] & intc_reg[tec_pkg::INTC_EN_BIT];

   // ==========================================================
   // read mux; low byte of the wide channel reads the copy latched on a high read
   wire [7:0] lo_view = WIDE ? lo_rbuf_reg : count_reg[7:0];

   always_comb begin
      rdata_next = 8'h00;
      if (rd) begin
         unique case (addr)
            tec_pkg::ADDR_CTRL:   rdata_next = ctrl_reg;
            tec_pkg::ADDR_CNT_LO: rdata_next = lo_view;
            tec_pkg::ADDR_CNT_HI: rdata_next = count_reg[15:8];
            tec_pkg::ADDR_INTC:   rdata_next = intc_reg;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg    <= tec_pkg::tec_ctrl_t'(tec_pkg::CTRL_RESET);
         pw_reg      <= tec_pkg::PW_WAIT;
         count_reg   <= tec_pkg::CNT_RESET;
         preload_reg <= tec_pkg::CNT_RESET;
         psc_reg     <= 7'h00;
         intc_reg    <= tec_pkg::INTC_RESET;
         rdata_reg   <= 8'h00;
         wake_reg    <= 1'b0;
      end else if (ce) begin
         ctrl_reg    <= ctrl_next;
         pw_reg      <= pw_next;
         count_reg   <= count_next;
         preload_reg <= preload_next;
         psc_reg     <= psc_next;
         intc_reg    <= intc_next;
         rdata_reg   <= rdata_next;
         wake_reg    <= overflow && power_down;
      end
   end

   // byte buffers of the wide channel
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lo_wbuf_reg <= 8'h00;
         lo_rbuf_reg <= 8'h00;
      end else if (ce) begin
         if (wr_lo && WIDE) begin
            lo_wbuf_reg <= wdata;
         end
         if (rd_hi) begin
            lo_rbuf_reg <= count_reg[7:0];
         end
      end
   end

   assign rdata   = rdata_reg;
   assign wake_up = wake_reg;

endmodule : tec_channel
`default_nettype wire

/* File: verilog/tec_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module tec_edge_sync (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic ce,
   // asynchronous input
   input  wire logic async_in,
   // synchronised rising and falling edges
   output logic      rise,
   output logic      fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // ==========================================================
   // two-stage synchroniser, edge taken after the second stage only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         // start at the pulled-up idle level, so no false rising edge follows reset
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else if (ce) begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule : tec_edge_sync
`default_nettype wire

/* File: verilog/tec_pkg.sv */
// Operation
// - mode comes from control bits 7 and 6
// - run bit 4 high lets counter run, low stops it
// - 8-bit channel divides internal clock by two to the power of prescale field bits 2..0
// - prescale field has no effect with the external pin as clock
// - edge select bit 3 picks pin polarity in event and pulse modes
// - wide channel clocks from sub clock or system clock over four, no prescaler
// - timer mode adds one per prescaled clock while running
// - overflow at full count raises request, reloads preload, keeps counting
// - interrupt enable bit low keeps overflow request off the interrupt line
// - event mode counts pin transitions directly, bypassing the prescaler
// - event mode counts rising edges when select is zero, falling when one
// - event mode counts in power down; overflow there also wakes
// - mode bits both one select pulse width measurement
// - pulse mode run bit only arms; counting starts at first active edge
// - pulse mode, select zero: start on fall, stop and clear run on rise
// - pulse mode, select one: start on rise, stop and clear run on fall
// - hardware clears run only in pulse mode; otherwise software alone
// - after a pulse the count holds and pin edges are ignored until rerun
// - pulse mode starts and stops on pin transitions, not levels
// - counter runs from preload up to FF or FFFF, then overflows
// - preload write when stopped loads counter; when running waits for overflow
// - wide low write buffered until high write; high read latches low byte
package tec_pkg;

   // ==========================================================
   // register offsets
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_CNT_LO = 2'h1;
   localparam logic [1:0] ADDR_CNT_HI = 2'h2;
   localparam logic [1:0] ADDR_INTC   = 2'h3;

   // ==========================================================
   // field positions and reset values
   localparam int         INTC_EN_BIT   = 0;
   localparam int         INTC_FLAG_BIT = 1;
   localparam int         CLK_SRC_BIT   = 5;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] INTC_RESET    = 8'h00;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] FULL_NARROW  = 16'h00FF;
   localparam logic [15:0] FULL_WIDE    = 16'hFFFF;

   // ==========================================================
   // timing counts
   localparam int         PSC_STAGES = 7;
   localparam logic [6:0] DIV4_MASK  = 7'h03;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_IDLE  = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_TIMER = 2'b10,
      MODE_PULSE = 2'b11
   } tec_mode_t;

   typedef enum logic {
      PW_WAIT    = 1'b0,
      PW_MEASURE = 1'b1
   } tec_pw_t;

   typedef struct packed {
      logic [1:0] mode;
      logic       clk_src;
      logic       run;
      logic       active_edge;
      logic [2:0] psc;
   } tec_ctrl_t;

endpackage : tec_pkg
